/* pin_select_pkg.sv */
/*
  Shared constants for the peripheral pin select unit: register map, field widths,
  reset values, selector codes and the lock sequence states.
  Assumes a 32-bit APB register bus with byte addresses, on a single clock.
*/
package pin_select_pkg;

  localparam int NUM_PINS = 16;           // Port A bits 0-7, then port B bits 0-7
  localparam int NUM_IN = 24;             // Remappable peripheral input functions
  localparam int NUM_SRC = 28;            // Code 0 plus peripheral sources 1..27
  localparam int OUT_W = 5;
  localparam int IN_W = 6;
  localparam int ADDR_W = 12;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] LOCK_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] IN_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] OUT_BASE = 12'h200;
  localparam logic [ADDR_W-1:0] BLOCK_MASK = 12'hF00;
  localparam int IDX_LSB = 2;
  localparam int IN_IDX_W = 6;
  localparam int OUT_IDX_W = 5;
  localparam logic [1:0] ALIGN_ZERO = 2'h0;

  // Lock register layout and unlock keys
  localparam int LOCK_BIT = 0;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Reset values
  localparam logic [OUT_W-1:0] OUT_SEL_RESET = 5'h00;
  localparam logic [IN_W-1:0] IN_SEL_RESET = 6'h00;  // Plain default pin for every input

  // Output selector codes
  localparam logic [OUT_W-1:0] SRC_LATCH = 5'h00;
  localparam logic [OUT_W-1:0] SRC_LOGIC_CELL_ONE = 5'h01;
  localparam logic [OUT_W-1:0] SRC_TIMER_ZERO = 5'h19;
  localparam logic [OUT_W-1:0] SRC_LAST = 5'h1B;

  // Highest pin index that exists on this unit
  localparam logic [IN_W-1:0] PIN_LAST = 6'h0F;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_GOT_FIRST = 2'b01,
    SEQ_ARMED = 2'b10
  } unlock_seq_t;

endpackage

/* pin_select_if.sv */
/*
  Carrier of the selection registers from the register block to the routing mux.
  Assumes both ends use pin_select_pkg.
*/
`timescale 1ns/1ps
interface pin_select_if;
  logic [pin_select_pkg::NUM_PINS-1:0][pin_select_pkg::OUT_W-1:0] out_sel;
  logic [pin_select_pkg::NUM_IN-1:0][pin_select_pkg::IN_W-1:0] in_sel;

  modport regs (output out_sel, output in_sel);
  modport mux (input out_sel, input in_sel);
endinterface

/* pin_route_mux.sv */
/*
  Combinational routing: peripheral sources onto pins and pins onto peripheral inputs.
  Assumes stable selections from the register block through pin_select_if.
*/
`timescale 1ns/1ps
module pin_route_mux (
  pin_select_if.mux sel,
  input wire logic [pin_select_pkg::NUM_SRC-1:1] periph_out,
  input wire logic [pin_select_pkg::NUM_PINS-1:0] port_latch,
  input wire logic [pin_select_pkg::NUM_PINS-1:0] pin_in,
  output logic [pin_select_pkg::NUM_PINS-1:0] pin_out,
  output logic [pin_select_pkg::NUM_IN-1:0] periph_in
);

  // Source vector with the port latch in slot 0 is built per pin
  genvar g;
  generate
    for (g = 0; g < pin_select_pkg::NUM_PINS; g++) begin : g_pin
      logic [pin_select_pkg::NUM_SRC-1:0] src;
      assign src = {periph_out, port_latch[g]};
      // Code zero keeps the ordinary latch; codes above the last source drive low
      always_comb begin
        if (sel.out_sel[g] == pin_select_pkg::SRC_LATCH) begin
          pin_out[g] = port_latch[g];
        end else if (sel.out_sel[g] <= pin_select_pkg::SRC_LAST) begin
          pin_out[g] = src[sel.out_sel[g]];
        end else begin
          pin_out[g] = 1'b0;
        end
      end
    end
    // Each input function has its own selector; unsupported indices give low
    for (g = 0; g < pin_select_pkg::NUM_IN; g++) begin : g_in
      always_comb begin
        if (sel.in_sel[g] <= pin_select_pkg::PIN_LAST) begin
          periph_in[g] = pin_in[sel.in_sel[g][3:0]];
        end else begin
          periph_in[g] = 1'b0;
        end
      end
    end
  endgenerate

endmodule

/* peripheral_pin_select_mux.sv */
/*
  Peripheral pin select unit: APB register file with lock, unlock sequence and
  one-way lock option, feeding the routing mux.
  Assumes presetn is the power-on/brown-out reset and other_reset is a synchronous
  pulse for every other device reset; pins and peripherals are on pclk.
  Limitation: every input defaults to pin index zero, and indices above the last
  pin route a low level rather than an undefined one.
*/
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Output source register: 5 writable bits, top three read zero
// - Output selectors clear on power-on reset, survive other resets
// - Codes 0x01-0x1B pick the 27 peripheral outputs in fixed order
// - Input select register: 6 writable bits, top two read zero
// - Input selects load their default on power-on, survive other resets
// - One dedicated input select register per remappable input function
// - Pin indices 0x00-0x0F are port A then port B bits
// - While locked, writes to all selection registers are ignored
// - With one-way option, lock once set stays set until reset
// - Power-on reset restores selections and removes permanent lock
module peripheral_pin_select_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic other_reset,
  input wire logic one_way_lock_option,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pin_select_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pin_select_pkg::NUM_SRC-1:1] periph_out,
  input wire logic [pin_select_pkg::NUM_PINS-1:0] port_latch,
  input wire logic [pin_select_pkg::NUM_PINS-1:0] pin_in,
  output logic [pin_select_pkg::NUM_PINS-1:0] pin_out,
  output logic [pin_select_pkg::NUM_IN-1:0] periph_in,
  output logic selection_lock_bit
);

  // All state in one record: key stage, lock, permanent lock, selections, bus reply
  typedef struct packed {
    pin_select_pkg::unlock_seq_t seq;
    logic lock;
    logic permanent;
    logic [pin_select_pkg::NUM_IN-1:0][pin_select_pkg::IN_W-1:0] in_sel;
    logic [pin_select_pkg::NUM_PINS-1:0][pin_select_pkg::OUT_W-1:0] out_sel;
    logic [31:0] rdata;
    logic err;
  } state_t;

  state_t state_q;
  state_t state_d;

  // Bus phase qualifiers
  logic setup;
  logic wr_access;
  logic lock_wr;
  logic sel_wr_open;

  // Address decode pieces
  logic word_aligned;
  logic in_block;
  logic out_block;
  logic hit_lock;
  logic hit_in;
  logic hit_out;
  logic [pin_select_pkg::IN_IDX_W-1:0] in_idx;
  logic [pin_select_pkg::OUT_IDX_W-1:0] out_idx;

  // Write data fields; only the low byte of a word is implemented anywhere
  logic [7:0] wbyte;
  logic [pin_select_pkg::IN_W-1:0] in_field;
  logic [pin_select_pkg::OUT_W-1:0] out_field;
  logic new_lock;
  logic key_first_hit;
  logic key_second_hit;

  pin_select_if sel_bus ();

  // Bus phases: setup captures read data, access commits writes
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign lock_wr = wr_access && hit_lock;
  // Locked selection writes are dropped without an error, so drivers need no retry path
  assign sel_wr_open = wr_access && !state_q.lock;

  // Address decode; only aligned words inside an implemented range are mapped
  assign in_idx = paddr[pin_select_pkg::IDX_LSB +: pin_select_pkg::IN_IDX_W];
  assign out_idx = paddr[pin_select_pkg::IDX_LSB +: pin_select_pkg::OUT_IDX_W];
  assign word_aligned = paddr[pin_select_pkg::IDX_LSB-1:0] == pin_select_pkg::ALIGN_ZERO;
  assign in_block = (paddr & pin_select_pkg::BLOCK_MASK) == pin_select_pkg::IN_BASE;
  assign out_block = (paddr & pin_select_pkg::BLOCK_MASK) == pin_select_pkg::OUT_BASE;
  assign hit_lock = paddr == pin_select_pkg::LOCK_ADDR;
  // The input index spans bits 7:2, so its range check alone bounds the block
  assign hit_in = in_block && word_aligned && 32'(in_idx) < pin_select_pkg::NUM_IN;
  // The output index stops below bit 7, which must then be clear
  assign hit_out = out_block && word_aligned && 32'(out_idx) < pin_select_pkg::NUM_PINS
    && !paddr[pin_select_pkg::IDX_LSB + pin_select_pkg::OUT_IDX_W];

  // Write data fields
  assign wbyte = pwdata[7:0];
  assign in_field = wbyte[pin_select_pkg::IN_W-1:0];
  assign out_field = wbyte[pin_select_pkg::OUT_W-1:0];
  assign new_lock = wbyte[pin_select_pkg::LOCK_BIT];
  assign key_first_hit = wbyte == pin_select_pkg::KEY_FIRST;
  assign key_second_hit = wbyte == pin_select_pkg::KEY_SECOND;

  // Next-state logic for the whole unit
  always_comb begin
    state_d = state_q;

    // Read data and error are captured in the setup phase, so no wait states
    if (setup) begin
      state_d.rdata = '0;
      state_d.err = !(hit_lock || hit_in || hit_out);
      if (hit_lock) begin
        state_d.rdata[pin_select_pkg::LOCK_BIT] = state_q.lock;
      end else if (hit_in) begin
        state_d.rdata[pin_select_pkg::IN_W-1:0] = state_q.in_sel[in_idx];
      end else if (hit_out) begin
        state_d.rdata[pin_select_pkg::OUT_W-1:0] = state_q.out_sel[out_idx];
      end
    end

    // Any write breaks a key sequence in progress unless the lock register case below keeps it going
    if (wr_access) begin
      state_d.seq = pin_select_pkg::SEQ_IDLE;
    end

    // Key sequence on the lock register; the value write returns it to idle
    if (lock_wr) begin
      case (state_q.seq)
        pin_select_pkg::SEQ_IDLE: begin
          // Only the first key opens the sequence
          if (key_first_hit) begin
            state_d.seq = pin_select_pkg::SEQ_GOT_FIRST;
          end
        end
        pin_select_pkg::SEQ_GOT_FIRST: begin
          // A repeated first key holds the first stage instead of restarting
          if (key_second_hit) begin
            state_d.seq = pin_select_pkg::SEQ_ARMED;
          end else if (key_first_hit) begin
            state_d.seq = pin_select_pkg::SEQ_GOT_FIRST;
          end
        end
        pin_select_pkg::SEQ_ARMED: begin
          // A permanent lock refuses the clear
          if (!state_q.permanent) begin
            state_d.lock = new_lock;
          end
          // The option is looked at only when the lock is written to one
          if (one_way_lock_option && new_lock) begin
            state_d.permanent = 1'b1;
          end
        end
        default: begin
          state_d.seq = pin_select_pkg::SEQ_IDLE;
        end
      endcase
    end

    // Selection writes land only while unlocked; the access still completes
    if (sel_wr_open && hit_in) begin
      state_d.in_sel[in_idx] = in_field;
    end
    if (sel_wr_open && hit_out) begin
      state_d.out_sel[out_idx] = out_field;
    end

    // Other resets drop the lock state but keep every selection
    if (other_reset) begin
      state_d.seq = pin_select_pkg::SEQ_IDLE;
      state_d.lock = 1'b0;
      state_d.permanent = 1'b0;
    end
  end

  // Power-on reset restores selections and removes the permanent lock
  // The reset branch loads constants only, so nothing leaks across a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q.seq <= pin_select_pkg::SEQ_IDLE;
      state_q.lock <= 1'b0;
      state_q.permanent <= 1'b0;
      state_q.in_sel <= {pin_select_pkg::NUM_IN{pin_select_pkg::IN_SEL_RESET}};
      state_q.out_sel <= {pin_select_pkg::NUM_PINS{pin_select_pkg::OUT_SEL_RESET}};
      state_q.rdata <= '0;
      state_q.err <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Bus answers: always ready, error only on unmapped addresses
  assign pready = 1'b1;
  assign prdata = state_q.rdata;
  // The error is held back to the access phase so a setup cycle never shows it
  assign pslverr = state_q.err && psel && penable;

  // The lock bit is also a status for other logic of the device
  assign selection_lock_bit = state_q.lock;

  // Selections leave straight from the registers; routing adds no register stage
  assign sel_bus.out_sel = state_q.out_sel;
  assign sel_bus.in_sel = state_q.in_sel;

  // Routing stays combinational so a pin follows its selector in the same cycle
  pin_route_mux u_route (
    .sel(sel_bus.mux),
    .periph_out(periph_out),
    .port_latch(port_latch),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .periph_in(periph_in)
  );

endmodule

/* pin_select_assertions.sv */
/*
  Concurrent checks on the pin select unit's top-level ports.
  Assumes pclk domain only, presetn active low, zero-wait APB.
*/
`timescale 1ns/1ps
module pin_select_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic other_reset,
  input wire logic one_way_lock_option,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pin_select_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [pin_select_pkg::NUM_PINS-1:0] port_latch,
  input wire logic [pin_select_pkg::NUM_PINS-1:0] pin_in,
  input wire logic [pin_select_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [pin_select_pkg::NUM_IN-1:0] periph_in,
  input wire logic selection_lock_bit
);
  // Access phase and lock register writes
  wire acc = psel && penable;
  wire lock_wr = acc && pwrite && paddr == 12'h000;
  logic perm_q;

  // Remembers a one-way lock; only a reset may drop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perm_q <= 1'b0;
    end else begin
      perm_q <= !other_reset && (perm_q || ($rose(selection_lock_bit) && one_way_lock_option));
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_out_upper_zero: assert property (acc && paddr[11:8] == 4'h2 |-> prdata[31:5] == 27'h0)
    else $error("output select upper bits not zero");
  chk_in_upper_zero: assert property (acc && paddr[11:8] == 4'h1 |-> prdata[31:6] == 26'h0)
    else $error("input select upper bits not zero");
  chk_reset_route:
    assert property ($rose(presetn) |-> pin_out == port_latch && periph_in == {24{pin_in[0]}})
    else $error("routing after power-on reset wrong");
  chk_set_cause: assert property (!(lock_wr && pwdata[0]) |=> !$rose(selection_lock_bit))
    else $error("lock set without a lock write");
  chk_lock_steady: assert property (!lock_wr && !other_reset |=> $stable(selection_lock_bit))
    else $error("lock changed without a lock write");
  chk_one_way: assert property (perm_q && !other_reset |=> selection_lock_bit)
    else $error("one-way lock was cleared");
  chk_other_clear: assert property (other_reset |=> !selection_lock_bit)
    else $error("lock survived other reset");
  chk_map_ok:
    assert property (acc && paddr[11:8] == 4'h1 && paddr[7:2] < 6'h18 && paddr[1:0] == 2'h0
      |-> !pslverr)
    else $error("input select register refused");
endmodule

bind peripheral_pin_select_mux pin_select_assertions pin_select_assertions_inst (
  .pclk(pclk), .presetn(presetn), .other_reset(other_reset),
  .one_way_lock_option(one_way_lock_option), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .port_latch(port_latch), .pin_in(pin_in), .pin_out(pin_out), .periph_in(periph_in),
  .selection_lock_bit(selection_lock_bit)
);

/* pin_side_model.sv */
/*
  Pins and peripherals beside the pin select unit.
  Assumes pclk; values move every cycle so a wrong route shows.
*/
`timescale 1ns/1ps
module pin_side_model (
  input wire logic pclk,
  output logic [27:1] periph_out,
  output logic [15:0] port_latch,
  output logic [15:0] pin_in
);
  logic [31:0] cnt_q = 32'h0;

  // Scrambled counter: sources rarely agree with each other
  always @(posedge pclk) cnt_q <= cnt_q + 32'h1;
  assign periph_out = 27'(cnt_q * 32'h9E3779B1);
  assign pin_in = 16'((cnt_q * 32'h85EBCA6B) >> 7); // Only pins 0x00-0x0F exist
  assign port_latch = ~pin_in ^ 16'(cnt_q);
endmodule

/* peripheral_pin_select_mux_tb.sv */
/*
  Self-checking bench for the pin select unit over APB.
  Assumes pin_side_model on the far side and the bound checker.
*/
`timescale 1ns/1ps
module peripheral_pin_select_mux_tb;
  logic pclk, presetn, other_reset, one_way_lock_option, psel, penable, pwrite, pready;
  logic pslverr, er, selection_lock_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [27:1] periph_out;
  logic [15:0] port_latch, pin_in, pin_out;
  logic [23:0] periph_in;
  int err_total = 0;
  int cmp_count = 0;

  peripheral_pin_select_mux peripheral_pin_select_mux_inst (.pclk(pclk), .presetn(presetn),
    .other_reset(other_reset), .one_way_lock_option(one_way_lock_option), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_out(periph_out), .port_latch(port_latch),
    .pin_in(pin_in), .pin_out(pin_out), .periph_in(periph_in),
    .selection_lock_bit(selection_lock_bit));
  pin_side_model pin_side_model_inst (.pclk(pclk), .periph_out(periph_out),
    .port_latch(port_latch), .pin_in(pin_in));

  // Free-running 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer; an idle edge follows so strobes never toggle twice at once
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask

  task unlock(input logic [31:0] v);
    apb(1'b1, 12'h000, 32'h55);
    apb(1'b1, 12'h000, 32'hAA);
    apb(1'b1, 12'h000, v);
  endtask

  task t_reset;
    rdk("out0", 12'h200, 32'h0);
    rdk("in0", 12'h100, 32'h0);
    @(negedge pclk);
    chk("latch", pin_out, port_latch);
    chk("in_dflt", periph_in, {24{pin_in[0]}});
    @(posedge pclk);
  endtask

  task t_codes;
    for (int c = 1; c < 28; c++) begin
      apb(1'b1, 12'h20C, 32'(c));
      @(negedge pclk);
      chk("route", pin_out[3], periph_out[c]);
      chk("pin2", pin_out[2], port_latch[2]);
      @(posedge pclk);
    end
    apb(1'b1, 12'h20C, 32'hFF);
    @(negedge pclk);
    chk("rsvd", pin_out[3], 1'b0);
    @(posedge pclk);
    rdk("out_w", 12'h20C, 32'h1F);
  endtask

  // Pin indices stay within 0x00-0x0F, the range every input supports
  task t_inputs;
    apb(1'b1, 12'h114, 32'hCF);
    apb(1'b1, 12'h100, 32'h0A);
    rdk("in_w", 12'h114, 32'h0F);
    @(negedge pclk);
    chk("in5", periph_in[5], pin_in[15]);
    chk("intr", periph_in[0], pin_in[10]);
    chk("in6", periph_in[6], pin_in[0]);
    @(posedge pclk);
    rdk("last", 12'h15C, 32'h0);
  endtask

  task t_lock;
    apb(1'b1, 12'h000, 32'h1);
    chk("nokey", selection_lock_bit, 1'b0);
    unlock(32'h1);
    chk("lock", selection_lock_bit, 1'b1);
    apb(1'b1, 12'h20C, 32'h05);
    rdk("locked", 12'h20C, 32'h1F);
    unlock(32'h0);
    apb(1'b1, 12'h20C, 32'h05);
    rdk("open", 12'h20C, 32'h05);
    apb(1'b0, 12'h300, 32'h0);
    chk("unmap", er, 1'b1);
  endtask

  task t_oneway;
    one_way_lock_option <= 1'b1;
    unlock(32'h1);
    unlock(32'h0);
    chk("perm", selection_lock_bit, 1'b1);
    other_reset <= 1'b1;
    @(posedge pclk);
    other_reset <= 1'b0;
    @(posedge pclk);
    chk("oth", selection_lock_bit, 1'b0);
    rdk("kept", 12'h20C, 32'h05);
    rdk("kept_in", 12'h114, 32'h0F);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdk("por", 12'h20C, 32'h0);
    chk("por_lock", selection_lock_bit, 1'b0);
  endtask

  // Main sequence
  initial begin
    {presetn, other_reset, one_way_lock_option, psel, penable, pwrite} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_codes;
    t_inputs;
    t_lock;
    t_oneway;
    test_done;
  end

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    test_done;
  end
endmodule
